// ### hdl/rscp_clk_div.sv
`timescale 1ns/1ps
module rscp_clk_div
    import rscp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       run,
    input  wire logic [3:0] divCode,
    output logic            halfTick
);
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic [4:0] halfLimit;

    always_comb begin
        unique casez (divCode)
            4'b000?: halfLimit = 5'h00;
            4'b0010: halfLimit = 5'h01;
            4'b0011: halfLimit = 5'h03;
            4'b0100: halfLimit = 5'h07;
            4'b0101: halfLimit = 5'h0F;
            default: halfLimit = 5'h1F;
        endcase
        halfTick = run && (cnt_q == halfLimit);
        if (!run || halfTick) begin
            cnt_d = 5'h00;
        end else begin
            cnt_d = cnt_q + 5'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : rscp_clk_div

// ### hdl/rscp_pkg.sv
// Overview of operation
// - data byte shifted out, reply byte readable
// - control bit 4 enables the master
// - divider code selects serial clock ratio
// - pin bit 1 is active-low select
// - pin bit 2 enables radio clock
// - pin bit 0 drives chip enable
// - first transfer returns radio status byte
// - command byte, then data bytes, MSB first
// - read register, one to five bytes
// - write register, standby or power-down only; the code accepts it in any state
// - read payload, pop it afterwards
// - load transmit payload from byte zero
// - flush transmit queue, no data
// - resend last payload until write or flush
// - read top payload width, one byte
// - ack payload on pipe, three pending
// - transmit payload without auto acknowledge
// - no operation, returns status only
// - short register write keeps upper bytes
// - status shifted out after select falls
// - pipe field unreliable while interrupt falls
// - pin bits drive radio lines directly
package rscp_pkg;

    localparam logic [7:0] ADDR_PIN_CTL    = 8'h90;
    localparam logic [7:0] ADDR_SPI_DATA   = 8'hE5;
    localparam logic [7:0] ADDR_SPI_CTL    = 8'hE6;
    localparam logic [7:0] RST_PIN_CTL     = 8'h02;
    localparam logic [7:0] RST_SPI_DATA    = 8'h00;
    localparam logic [7:0] RST_SPI_CTL     = 8'h00;

    localparam int         BIT_CHIP_ENABLE = 0;
    localparam int         BIT_SELECT_B    = 1;
    localparam int         BIT_CLOCK_EN    = 2;
    localparam int         BIT_SPI_ENABLE  = 4;
    localparam int         DIV_MSB         = 3;

    localparam logic [7:0] CMD_REG_MASK    = 8'hE0;
    localparam logic [7:0] CMD_READ_REG    = 8'h00;
    localparam logic [7:0] CMD_WRITE_REG   = 8'h20;
    localparam logic [7:0] CMD_READ_RX     = 8'h61;
    localparam logic [7:0] CMD_READ_WIDTH  = 8'h60;
    localparam logic [7:0] CMD_WRITE_TX    = 8'hA0;
    localparam logic [7:0] CMD_ACK_MASK    = 8'hF8;
    localparam logic [7:0] CMD_ACK_PAYLOAD = 8'hA8;
    localparam logic [7:0] CMD_TX_NO_ACK   = 8'hB0;
    localparam logic [7:0] CMD_FLUSH_TX    = 8'hE1;
    localparam logic [7:0] CMD_FLUSH_RX    = 8'hE2;
    localparam logic [7:0] CMD_RESEND      = 8'hE3;
    localparam logic [7:0] CMD_NO_OP       = 8'hFF;

    localparam logic [5:0] MAX_REG_BYTES   = 6'h05;
    localparam logic [5:0] MAX_PLD_BYTES   = 6'h20;
    localparam logic [5:0] MAX_WIDTH_BYTES = 6'h01;
    localparam logic [5:0] BYTE_CNT_SAT    = 6'h21;
    localparam logic [2:0] MAX_PIPE        = 3'h5;
    localparam logic [1:0] MAX_ACK_PENDING = 2'h3;
    localparam logic [2:0] LAST_BIT        = 3'h7;

    typedef enum logic [3:0] {
        KIND_NONE        = 4'h0,
        KIND_READ_REG    = 4'h1,
        KIND_WRITE_REG   = 4'h2,
        KIND_READ_RX     = 4'h3,
        KIND_WRITE_TX    = 4'h4,
        KIND_FLUSH_TX    = 4'h5,
        KIND_FLUSH_RX    = 4'h6,
        KIND_RESEND      = 4'h7,
        KIND_READ_WIDTH  = 4'h8,
        KIND_ACK_PAYLOAD = 4'h9,
        KIND_TX_NO_ACK   = 4'hA,
        KIND_NO_OP       = 4'hB,
        KIND_UNKNOWN     = 4'hC
    } rscp_kind_t;

    typedef struct packed {
        logic       valid;
        rscp_kind_t kind;
        logic [4:0] addr;
        logic [5:0] index;
        logic [7:0] data;
    } rscp_cmd_event_t;

    typedef struct packed {
        logic [4:0] rsvd;
        logic       clockEn;
        logic       select_b;
        logic       chipEnable;
    } rscp_pin_ctl_t;

endpackage : rscp_pkg

// ### hdl/rscp_shifter.sv
`timescale 1ns/1ps
module rscp_shifter
    import rscp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic [7:0] txByte,
    input  wire logic       halfTick,
    input  wire logic       miso,
    output logic            busy,
    output logic            done,
    output logic [7:0]      rxByte,
    output logic            sck,
    output logic            mosi
);
    logic [7:0] shift_q, shift_d, rx_q, rx_d;
    logic [2:0] bit_q, bit_d;
    logic       busy_q, busy_d, done_q, done_d, sck_q, sck_d, mosi_q, mosi_d;

    always_comb begin
        shift_d = shift_q;
        rx_d    = rx_q;
        bit_d   = bit_q;
        busy_d  = busy_q;
        done_d  = 1'b0;
        sck_d   = sck_q;
        mosi_d  = mosi_q;
        if (abort) begin
            busy_d = 1'b0;
            sck_d  = 1'b0;
        end else if (!busy_q) begin
            if (start) begin
                busy_d  = 1'b1;
                shift_d = txByte;
                mosi_d  = txByte[7];
                bit_d   = 3'h0;
                sck_d   = 1'b0;
            end
        end else if (halfTick) begin
            sck_d = ~sck_q;
            if (!sck_q) begin
                rx_d = {rx_q[6:0], miso};
            end else if (bit_q == LAST_BIT) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                shift_d = {shift_q[6:0], 1'b0};
                mosi_d  = shift_q[6];
                bit_d   = bit_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            shift_q <= 8'h00;
            rx_q    <= 8'h00;
            bit_q   <= 3'h0;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
            sck_q   <= 1'b0;
            mosi_q  <= 1'b0;
        end else begin
            shift_q <= shift_d;
            rx_q    <= rx_d;
            bit_q   <= bit_d;
            busy_q  <= busy_d;
            done_q  <= done_d;
            sck_q   <= sck_d;
            mosi_q  <= mosi_d;
        end
    end

    assign busy   = busy_q;
    assign done   = done_q;
    assign rxByte = rx_q;
    assign sck    = sck_q;
    assign mosi   = mosi_q;
endmodule : rscp_shifter

// ### hdl/rscp_top.sv
`timescale 1ns/1ps
module rscp_top
    import rscp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] sfrAddr,
    input  wire logic [7:0] sfrWrData,
    input  wire logic       sfrWr,
    input  wire logic       sfrRd,
    output logic [7:0]      sfrRdData,
    output logic            spiReady,
    output logic            radioSelectPin_b,
    output logic            radioChipEnable,
    output logic            radioClockPin,
    output logic            spiSck,
    output logic            spiMosi,
    input  wire logic       spiMiso,
    input  wire logic       ackPayloadSent,
    output rscp_cmd_event_t cmdEvent,
    output logic            txFlush,
    output logic            rxFlush,
    output logic            rxPop,
    output logic            resendActive,
    output logic [1:0]      ackPending,
    output logic [7:0]      statusByte
);
    // ---------------- special-function registers
    rscp_pin_ctl_t pin_q, pin_d;
    logic [7:0]    ctl_q, ctl_d;
    logic [7:0]    data_q, data_d;
    logic [7:0]    txLatch_q, txLatch_d;
    logic [7:0]    rd_q, rd_d;
    logic          ready_q, ready_d;
    logic          selFall, selRise;
    logic          spiEnable;
    logic          startXfer;
    logic          halfTick, shBusy, shDone, shSck, shMosi;
    logic [7:0]    shRx;

    assign spiEnable = ctl_q[BIT_SPI_ENABLE];

    always_comb begin
        pin_d     = pin_q;
        ctl_d     = ctl_q;
        data_d    = data_q;
        txLatch_d = txLatch_q;
        ready_d   = ready_q;
        startXfer = 1'b0;
        if (sfrWr && sfrAddr == ADDR_PIN_CTL) begin
            pin_d      = rscp_pin_ctl_t'(sfrWrData);
            pin_d.rsvd = 5'h00;
        end
        if (sfrWr && sfrAddr == ADDR_SPI_CTL) begin
            ctl_d = {3'h0, sfrWrData[BIT_SPI_ENABLE:0]};
        end
        if (sfrWr && sfrAddr == ADDR_SPI_DATA && spiEnable && !shBusy) begin
            data_d    = sfrWrData;
            txLatch_d = sfrWrData;
            startXfer = 1'b1;
            ready_d   = 1'b0;
        end
        if (shDone) begin
            data_d  = shRx;
            ready_d = 1'b1;
        end
        if (!spiEnable) begin
            ready_d = 1'b1;
        end
        unique case (sfrAddr)
            ADDR_PIN_CTL:  rd_d = pin_q;
            ADDR_SPI_CTL:  rd_d = ctl_q;
            ADDR_SPI_DATA: rd_d = data_q;
            default:       rd_d = 8'h00;
        endcase
        if (!sfrRd) begin
            rd_d = rd_q;
        end
    end

    assign selFall = pin_q.select_b && !pin_d.select_b;
    assign selRise = !pin_q.select_b && pin_d.select_b;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_q     <= rscp_pin_ctl_t'(RST_PIN_CTL);
            ctl_q     <= RST_SPI_CTL;
            data_q    <= RST_SPI_DATA;
            txLatch_q <= RST_SPI_DATA;
            rd_q      <= 8'h00;
            ready_q   <= 1'b1;
        end else begin
            pin_q     <= pin_d;
            ctl_q     <= ctl_d;
            data_q    <= data_d;
            txLatch_q <= txLatch_d;
            rd_q      <= rd_d;
            ready_q   <= ready_d;
        end
    end

    // ---------------- serial engine
    rscp_clk_div u_div (
        .clk      (clk),
        .rst_b    (rst_b),
        .run      (shBusy),
        .divCode  (ctl_q[DIV_MSB:0]),
        .halfTick (halfTick)
    );

    rscp_shifter u_shift (
        .clk      (clk),
        .rst_b    (rst_b),
        .start    (startXfer),
        .abort    (!spiEnable),
        .txByte   (txLatch_d),
        .halfTick (halfTick),
        .miso     (spiMiso),
        .busy     (shBusy),
        .done     (shDone),
        .rxByte   (shRx),
        .sck      (shSck),
        .mosi     (shMosi)
    );

    // ---------------- command tracking
    rscp_kind_t      kind_q, kind_d;
    logic [4:0]      addr_q, addr_d;
    logic [5:0]      count_q, count_d;
    logic            gotData_q, gotData_d;
    logic            resend_q, resend_d;
    logic [1:0]      pend_q, pend_d;
    logic [7:0]      status_q, status_d;
    rscp_cmd_event_t ev_q, ev_d;
    logic            txFlush_q, txFlush_d, rxFlush_q, rxFlush_d, rxPop_q, rxPop_d;
    logic            ackQueue;
    logic [5:0]      dataIdx;
    logic [5:0]      limit;
    logic            refused;
    rscp_kind_t      newKind;

    function automatic rscp_kind_t decode(input logic [7:0] c);
        rscp_kind_t k;
        k = KIND_UNKNOWN;
        if ((c & CMD_REG_MASK) == CMD_READ_REG)       k = KIND_READ_REG;
        else if ((c & CMD_REG_MASK) == CMD_WRITE_REG) k = KIND_WRITE_REG;
        else if (c == CMD_READ_RX)                    k = KIND_READ_RX;
        else if (c == CMD_READ_WIDTH)                 k = KIND_READ_WIDTH;
        else if (c == CMD_WRITE_TX)                   k = KIND_WRITE_TX;
        else if ((c & CMD_ACK_MASK) == CMD_ACK_PAYLOAD) k = KIND_ACK_PAYLOAD;
        else if (c == CMD_TX_NO_ACK)                  k = KIND_TX_NO_ACK;
        else if (c == CMD_FLUSH_TX)                   k = KIND_FLUSH_TX;
        else if (c == CMD_FLUSH_RX)                   k = KIND_FLUSH_RX;
        else if (c == CMD_RESEND)                     k = KIND_RESEND;
        else if (c == CMD_NO_OP)                      k = KIND_NO_OP;
        return k;
    endfunction : decode

    always_comb begin
        unique case (kind_q)
            KIND_READ_REG, KIND_WRITE_REG:             limit = MAX_REG_BYTES;
            KIND_READ_RX, KIND_WRITE_TX, KIND_TX_NO_ACK,
            KIND_ACK_PAYLOAD:                          limit = MAX_PLD_BYTES;
            KIND_READ_WIDTH:                           limit = MAX_WIDTH_BYTES;
            default:                                   limit = 6'h00;
        endcase
        // pipes above five, or a full ack queue, take no bytes
        refused = (kind_q == KIND_ACK_PAYLOAD)
                  && (addr_q[2:0] > MAX_PIPE || pend_q == MAX_ACK_PENDING);
        dataIdx   = count_q - 6'h01;
        newKind   = decode(txLatch_q);
        kind_d    = kind_q;
        addr_d    = addr_q;
        count_d   = count_q;
        gotData_d = gotData_q;
        resend_d  = resend_q;
        status_d  = status_q;
        ev_d      = '0;
        txFlush_d = 1'b0;
        rxFlush_d = 1'b0;
        rxPop_d   = 1'b0;
        ackQueue  = 1'b0;
        if (selFall) begin
            count_d   = 6'h00;
            gotData_d = 1'b0;
            kind_d    = KIND_NONE;
        end else if (selRise) begin
            if (kind_q == KIND_READ_RX && gotData_q) begin
                rxPop_d = 1'b1;
            end
            if (kind_q == KIND_ACK_PAYLOAD && gotData_q) begin
                ackQueue = 1'b1;
            end
            kind_d = KIND_NONE;
        end else if (shDone && !pin_q.select_b) begin
            if (count_q == 6'h00) begin
                status_d = shRx;
                kind_d   = newKind;
                addr_d   = txLatch_q[4:0];
                unique case (newKind)
                    KIND_FLUSH_TX: begin
                        txFlush_d = 1'b1;
                        resend_d  = 1'b0;
                    end
                    KIND_FLUSH_RX: rxFlush_d = 1'b1;
                    KIND_RESEND:   resend_d  = 1'b1;
                    KIND_WRITE_TX: resend_d  = 1'b0;
                    default:       resend_d  = resend_q;
                endcase
            end else if (dataIdx < limit && !refused) begin
                // each byte lands at once, so a short write leaves upper bytes
                ev_d.valid = 1'b1;
                ev_d.kind  = kind_q;
                ev_d.addr  = addr_q;
                ev_d.index = dataIdx;
                gotData_d  = 1'b1;
                if (kind_q == KIND_READ_REG || kind_q == KIND_READ_RX
                    || kind_q == KIND_READ_WIDTH) begin
                    ev_d.data = shRx;
                end else begin
                    ev_d.data = txLatch_q;
                end
            end
            if (count_q != BYTE_CNT_SAT) begin
                count_d = count_q + 6'h01;
            end
        end
        pend_d = pend_q;
        if (ackQueue && !ackPayloadSent) begin
            pend_d = pend_q + 2'h1;
        end else if (!ackQueue && ackPayloadSent && pend_q != 2'h0) begin
            pend_d = pend_q - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            kind_q    <= KIND_NONE;
            addr_q    <= 5'h00;
            count_q   <= 6'h00;
            gotData_q <= 1'b0;
            resend_q  <= 1'b0;
            pend_q    <= 2'h0;
            status_q  <= 8'h00;
            ev_q      <= '0;
            txFlush_q <= 1'b0;
            rxFlush_q <= 1'b0;
            rxPop_q   <= 1'b0;
        end else begin
            kind_q    <= kind_d;
            addr_q    <= addr_d;
            count_q   <= count_d;
            gotData_q <= gotData_d;
            resend_q  <= resend_d;
            pend_q    <= pend_d;
            status_q  <= status_d;
            ev_q      <= ev_d;
            txFlush_q <= txFlush_d;
            rxFlush_q <= rxFlush_d;
            rxPop_q   <= rxPop_d;
        end
    end

    assign sfrRdData        = rd_q;
    assign spiReady         = ready_q;
    assign radioSelectPin_b = pin_q.select_b;
    assign radioChipEnable  = pin_q.chipEnable;
    assign radioClockPin    = pin_q.clockEn;
    // no extra stage, so miso is read as the sck pin rises
    assign spiSck           = shSck;
    assign spiMosi          = shMosi;
    assign cmdEvent         = ev_q;
    assign txFlush          = txFlush_q;
    assign rxFlush          = rxFlush_q;
    assign rxPop            = rxPop_q;
    assign resendActive     = resend_q;
    assign ackPending       = pend_q;
    assign statusByte       = status_q;
endmodule : rscp_top

// ### test/rscp_radio_model.sv
`timescale 1ns/1ps
module rscp_radio_model #(
    parameter logic [7:0] STATUS_VAL = 8'h0E,
    parameter logic [7:0] REPLY_VAL  = 8'hA5
) (
    input  wire logic       clk,
    input  wire logic       selB,
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            miso,
    output logic [7:0]      rxByte
);
    logic [7:0] shQ   = 8'h00;
    logic [2:0] cntQ  = 3'h0;
    logic       sckQ  = 1'b0;
    logic       idleQ = 1'b0;

    always @(posedge clk) begin
        sckQ  <= sck;
        idleQ <= ~idleQ;
        if (selB) begin
            shQ  <= STATUS_VAL;
            cntQ <= 3'h0;
        end else if (sck && !sckQ) begin
            // next bit goes out just after each rise, ready for the next one
            rxByte <= {rxByte[6:0], mosi};
            shQ    <= (cntQ == 3'h7) ? REPLY_VAL : {shQ[6:0], 1'b0};
            cntQ   <= cntQ + 3'h1;
        end
    end

    // deselected line toggles so a stale bit never looks valid
    assign miso = selB ? idleQ : shQ[7];
endmodule : rscp_radio_model

// ### test/rscp_top_bench.sv
`timescale 1ns/1ps
module rscp_top_bench
    import rscp_pkg::*;
;
    logic            clk, rst_b, sfrWr, sfrRd, miso, selB, ce, clkPin, sck, mosi, ackSent;
    logic            spiReady, txFlush, rxFlush, rxPop, resend;
    logic [7:0]      sfrAddr, sfrWrData, rdData, statusByte, modelRx, st, got;
    logic [1:0]      ackPending;
    rscp_cmd_event_t ev, lastEv;
    int              mismatches, n_compared, evN, txfN, rxfN, popN, k, n0;
    logic [7:0]      cmdTab [7] = '{8'h25, 8'h03, 8'h61, 8'hA0, 8'h60, 8'hB0, 8'hA8};
    rscp_kind_t      kindTab [7] = '{KIND_WRITE_REG, KIND_READ_REG, KIND_READ_RX,
        KIND_WRITE_TX, KIND_READ_WIDTH, KIND_TX_NO_ACK, KIND_ACK_PAYLOAD};
    int              lenTab [7] = '{2, 1, 1, 1, 1, 1, 1};

    rscp_top uut (.clk(clk), .rst_b(rst_b), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
        .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdData(rdData), .spiReady(spiReady),
        .radioSelectPin_b(selB), .radioChipEnable(ce), .radioClockPin(clkPin),
        .spiSck(sck), .spiMosi(mosi), .spiMiso(miso), .ackPayloadSent(ackSent),
        .cmdEvent(ev), .txFlush(txFlush), .rxFlush(rxFlush), .rxPop(rxPop),
        .resendActive(resend), .ackPending(ackPending), .statusByte(statusByte));

    rscp_radio_model radio (.clk(clk), .selB(selB), .sck(sck), .mosi(mosi), .miso(miso),
        .rxByte(modelRx));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (ev.valid === 1'b1) begin
            evN++;
            lastEv <= ev;
        end
        if (txFlush === 1'b1) txfN++;
        if (rxFlush === 1'b1) rxfN++;
        if (rxPop === 1'b1) popN++;
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfrAddr   <= a;
        sfrWrData <= d;
        sfrWr     <= 1'b1;
        @(posedge clk);
        sfrWr <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfrAddr <= a;
        sfrRd   <= 1'b1;
        @(posedge clk);
        sfrRd <= 1'b0;
        @(posedge clk);
        #1 d = rdData;
    endtask : rd

    task automatic xfer(input logic [7:0] d, output logic [7:0] r);
        int i;
        wr(ADDR_SPI_DATA, d);
        for (i = 0; i < 2000; i++) begin
            @(posedge clk);
            #1;
            if (spiReady === 1'b1) break;
        end
        if (i == 2000) begin
            mismatches++;
            test_done();
        end
        rd(ADDR_SPI_DATA, r);
    endtask : xfer

    task automatic cmd(input logic [7:0] c, input int n);
        int i;
        wr(ADDR_PIN_CTL, 8'h00);
        xfer(c, st);
        for (i = 0; i < n; i++) xfer(8'h40 + 8'(i), got);
        wr(ADDR_PIN_CTL, 8'h02);
    endtask : cmd

    initial begin
        {rst_b, sfrWr, sfrRd, sfrAddr, sfrWrData, ackSent} = '0;
        {mismatches, n_compared, evN, txfN, rxfN, popN} = '0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd(ADDR_PIN_CTL, got);
        chk("pin ctl reset", RST_PIN_CTL, got);
        rd(ADDR_SPI_DATA, got);
        chk("data reset", RST_SPI_DATA, got);
        rd(ADDR_SPI_CTL, got);
        chk("spi ctl reset", RST_SPI_CTL, got);
        rd(8'h91, got);
        chk("unmapped", 8'h00, got);
        chk("select pin", 8'h01, {7'h00, selB});
        $display("test reset done");
        wr(ADDR_PIN_CTL, 8'hFF);
        rd(ADDR_PIN_CTL, got);
        chk("pin ctl rw", 8'h07, got);
        repeat (1000) @(posedge clk);
        chk("pins", 8'h07, {5'h00, clkPin, selB, ce});
        $display("test pins done");
        wr(ADDR_PIN_CTL, 8'h00);
        wr(ADDR_SPI_DATA, 8'h33);
        repeat (20) @(posedge clk);
        #1 chk("ready disabled", 8'h01, {7'h00, spiReady});
        rd(ADDR_SPI_DATA, got);
        chk("data disabled", 8'h00, got);
        $display("test disabled done");
        for (k = 0; k < 7; k++) begin
            wr(ADDR_SPI_CTL, 8'h10 | 8'(k));
            cmd(CMD_NO_OP, 0);
            chk("status", 8'h0E, st);
            chk("sent", CMD_NO_OP, modelRx);
        end
        chk("status port", 8'h0E, statusByte);
        $display("test divider done");
        wr(ADDR_SPI_CTL, 8'h10);
        for (k = 0; k < 7; k++) begin
            n0 = evN;
            cmd(cmdTab[k], lenTab[k]);
            chk("events", 8'(lenTab[k]), 8'(evN - n0));
            chk("kind", {4'h0, kindTab[k]}, {4'h0, lastEv.kind});
        end
        chk("pop", 8'h01, 8'(popN));
        chk("ack pending", 8'h01, {6'h00, ackPending});
        cmd(8'hAE, 1);
        chk("bad pipe", 8'h01, {6'h00, ackPending});
        cmd(8'hA9, 1);
        cmd(8'hAA, 1);
        n0 = evN;
        cmd(8'hAB, 1);
        chk("ack full", 8'h03, {6'h00, ackPending});
        chk("ack full events", 8'h00, 8'(evN - n0));
        ackSent <= 1'b1;
        @(posedge clk);
        ackSent <= 1'b0;
        @(posedge clk);
        #1 chk("ack sent", 8'h02, {6'h00, ackPending});
        cmd(8'h25, 2);
        chk("addr", 8'h05, {3'h0, lastEv.addr});
        chk("index", 8'h01, {2'h0, lastEv.index});
        chk("wdata", 8'h41, lastEv.data);
        cmd(CMD_READ_REG, 1);
        chk("rdata", 8'hA5, lastEv.data);
        $display("test commands done");
        cmd(CMD_RESEND, 0);
        chk("resend on", 8'h01, {7'h00, resend});
        cmd(CMD_FLUSH_TX, 0);
        chk("resend off", 8'h00, {7'h00, resend});
        chk("tx flush", 8'h01, 8'(txfN));
        cmd(CMD_FLUSH_RX, 0);
        chk("rx flush", 8'h01, 8'(rxfN));
        $display("test flush done");
        test_done();
    end
endmodule : rscp_top_bench

bind rscp_top rscp_top_sva chkI (.clk(clk), .rst_b(rst_b), .sfrAddr(sfrAddr),
    .sfrWrData(sfrWrData), .sfrWr(sfrWr), .spiReady(spiReady),
    .radioSelectPin_b(radioSelectPin_b), .radioChipEnable(radioChipEnable),
    .radioClockPin(radioClockPin), .spiSck(spiSck), .spiMosi(spiMosi),
    .txFlush(txFlush), .resendActive(resendActive));

// ### test/rscp_top_sva.sv
`timescale 1ns/1ps
module rscp_top_sva
    import rscp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] sfrAddr,
    input  wire logic [7:0] sfrWrData,
    input  wire logic       sfrWr,
    input  wire logic       spiReady,
    input  wire logic       radioSelectPin_b,
    input  wire logic       radioChipEnable,
    input  wire logic       radioClockPin,
    input  wire logic       spiSck,
    input  wire logic       spiMosi,
    input  wire logic       txFlush,
    input  wire logic       resendActive
);
    logic       enQ;
    logic       sckQ;
    logic [3:0] divQ;
    logic [5:0] hiQ;
    logic [3:0] riseQ;
    logic       pinWr;
    logic       datWr;

    assign pinWr = sfrWr && sfrAddr == ADDR_PIN_CTL;
    assign datWr = sfrWr && sfrAddr == ADDR_SPI_DATA;

    function automatic logic [5:0] halfOf(input logic [3:0] c);
        case (c)
            4'h0, 4'h1: return 6'h01;
            4'h2:       return 6'h02;
            4'h3:       return 6'h04;
            4'h4:       return 6'h08;
            4'h5:       return 6'h10;
            default:    return 6'h20;
        endcase
    endfunction : halfOf

    // mirror of enable and divider, sck high time and rises per byte
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            enQ   <= 1'b0;
            divQ  <= 4'h0;
            sckQ  <= 1'b0;
            hiQ   <= 6'h00;
            riseQ <= 4'h0;
        end else begin
            if (sfrWr && sfrAddr == ADDR_SPI_CTL) begin
                enQ  <= sfrWrData[BIT_SPI_ENABLE];
                divQ <= sfrWrData[3:0];
            end
            sckQ  <= spiSck;
            hiQ   <= spiSck ? hiQ + 6'h01 : 6'h00;
            riseQ <= spiReady ? 4'h0 : riseQ + {3'h0, spiSck && !sckQ};
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence seqStart;
        datWr && enQ && spiReady;
    endsequence

    chk_xfer_start: assert property (seqStart |=> !spiReady)
        else $error("data write did not start a transfer");
    chk_disabled_ignore: assert property (datWr && !enQ && spiReady |=> spiReady && !spiSck)
        else $error("disabled master reacted to a data write");
    chk_busy_bounded: assert property ($fell(spiReady) |-> ##[1:600] spiReady)
        else $error("transfer never completed");
    chk_sck_half: assert property ($fell(spiSck) |-> hiQ == halfOf(divQ))
        else $error("serial clock high time wrong for divider");
    chk_eight_bits: assert property ($rose(spiReady) |-> riseQ == 4'h8)
        else $error("transfer did not clock eight bits");
    chk_mosi_steady: assert property ($rose(spiSck) |-> $stable(spiMosi))
        else $error("data out moved at clock rise");
    chk_idle_sck: assert property (spiReady |-> !spiSck)
        else $error("serial clock high while idle");
    chk_select_pin: assert property (pinWr |=> radioSelectPin_b == $past(sfrWrData[1]))
        else $error("select pin does not follow bit 1");
    chk_ce_pin: assert property (pinWr |=> radioChipEnable == $past(sfrWrData[0]))
        else $error("chip enable does not follow bit 0");
    chk_clk_pin: assert property (pinWr |=> radioClockPin == $past(sfrWrData[2]))
        else $error("clock enable does not follow bit 2");
    chk_pins_hold: assert property (!pinWr |=> $stable({radioSelectPin_b, radioChipEnable,
                                                       radioClockPin}))
        else $error("radio pins moved without a write");
    chk_resend_off: assert property (txFlush |-> ##[0:2] !resendActive)
        else $error("transmit flush left resend active");
endmodule : rscp_top_sva
